/* logic/pnpcc_top.sv */
// Card side configuration state, command decode and resource data stream
`timescale 1ns/1ps
// Overview of operation
// - Bus reset: wait-for-key state, select number zero
// - Load defaults; strap low or default activates
// - Command bits self clear after execution
// - Command 0x01 reloads defaults, keeps port/number/state
// - Command 0x02 enters wait-for-key, keeps number
// - Command 0x04 clears select number outside wait-for-key
// - Command 0x07 acts as bus reset, except that the read answer registers are not cleared
// - Read port address from write bits 9..2
// - Isolation reads answered only when isolating
// - Wake zero isolates sleeping unnumbered cards
// - Wake matching nonzero number enters configuration
// - Mismatched wake returns isolating/configuring card to sleep
// - Single byte source, rewound by nonzero wake
// - Resource reads return next byte in order
// - Status bit zero flags next byte ready
// - Logical device number always reads zero
// - Range check returns 0x55 or 0xaa
// - Activate bit zero read/write gates device
// - Storage words hold data bit reversed
// - Nonzero wake points source at byte 0x16
module pnpcc_top (
  input  wire logic        ref_clk,         // 100 MHz clock
  input  wire logic        resetn,          // Bus reset, synchronous, active low
  input  wire logic        init_key,        // Pulse: initiation key recognised
  input  wire logic [15:0] io_addr,         // I/O address of the current strobe
  input  wire logic        io_wr,           // Pulse: I/O write
  input  wire logic        io_rd,           // Pulse: I/O read
  input  wire logic [7:0]  io_wdata,        // I/O write data
  input  wire logic        io_range_hit,    // Address falls in assigned range
  input  wire logic        activate_strap_pin, // Strap pin, active low
  output logic      [7:0]  io_rdata,        // Read answer byte
  output logic             io_rd_hit,       // Pulse: card answers the read
  output logic      [15:0] read_port_addr,  // Programmed read port address
  output logic      [1:0]  card_state,      // Configuration state
  output logic      [7:0]  card_select,     // Card select number
  output logic             device_active,   // Logical device active
  output logic             ee_req,          // Word fetch request
  output logic      [6:0]  ee_addr,         // Word address
  input  wire logic        ee_ack,          // Pulse: word returned
  input  wire logic [15:0] ee_word          // Stored word, bit reversed
);

  // Card state and fetch engine state
  pnpcc_pkg::pnpcc_state_t state;
  pnpcc_pkg::pnpcc_fetch_t fetch;

  // Registers, stream pointer, buffer and identifier walk
  logic [7:0]  reg_index;
  logic [7:0]  rdport;
  logic [7:0]  csn;
  logic [1:0]  range_chk;
  logic        act;
  logic [2:0]  cc_cmd;
  logic [7:0]  ptr;
  logic [7:0]  fetched;
  logic        fetched_vld;
  logic        strap_s1;
  logic        strap_s2;
  logic [7:0]  buf0;
  logic [7:0]  buf1;
  logic [1:0]  buf_cnt;
  logic [2:0]  id_bit;
  logic        id_phase;

  // Strap pin synchroniser
  // The strap comes straight from the board, so only the second stage is
  // read; no reset is needed since the default load waits for a word
  // fetch, which takes longer than the two stages need to settle
  always_ff @(posedge ref_clk)
  begin
    strap_s1 <= activate_strap_pin;
    strap_s2 <= strap_s1;
  end

  // Port and access decode
  // All configuration ports are ignored in wait-for-key; the initiation
  // key logic outside the block is the only way out of that state.
  // Writes that a state refuses are dropped here, so the register
  // processes below only see accepted strobes
  wire         any_reset   = (cc_cmd == pnpcc_pkg::CC_ALL);
  wire         wr_addr     = io_wr && (io_addr == pnpcc_pkg::ADDR_PORT) && (state != pnpcc_pkg::ST_WAIT_KEY);
  wire         wr_data     = io_wr && (io_addr == pnpcc_pkg::WDATA_PORT) && (state != pnpcc_pkg::ST_WAIT_KEY);
  wire [15:0]  rdport_full = {pnpcc_pkg::RDPORT_HIGH, rdport, pnpcc_pkg::RDPORT_LOW};
  wire         rd_port     = io_rd && (io_addr == rdport_full) && (state != pnpcc_pkg::ST_WAIT_KEY);
  wire         in_cfg      = (state == pnpcc_pkg::ST_CONFIG);
  wire         in_iso      = (state == pnpcc_pkg::ST_ISOLATE);
  wire         wr_rdport   = wr_data && in_iso && (reg_index == pnpcc_pkg::IDX_SET_RDPORT);
  wire         wr_cc       = wr_data && (reg_index == pnpcc_pkg::IDX_CFG_CTRL);
  wire         wr_wake     = wr_data && (reg_index == pnpcc_pkg::IDX_WAKE);
  wire         wr_csn      = wr_data && (in_iso || in_cfg) && (reg_index == pnpcc_pkg::IDX_CSN);
  wire         wr_act      = wr_data && in_cfg && (reg_index == pnpcc_pkg::IDX_ACTIVATE);
  wire         wr_rc       = wr_data && in_cfg && (reg_index == pnpcc_pkg::IDX_RANGE_CHK);
  wire         wake_zero   = wr_wake && (io_wdata == pnpcc_pkg::CSN_RESET);
  wire         wake_match  = wr_wake && !wake_zero && (io_wdata == csn);
  wire         wake_rewind = wr_wake && !wake_zero;

  // Buffer head and handshakes
  // The serial identifier and the resource data share one byte stream.
  // In isolation the head byte is walked bit by bit, lsb first, two
  // reads per bit; in configuration each resource data read pops one whole byte
  wire         buf_valid   = (buf_cnt != 2'd0);
  wire         buf_ready   = (buf_cnt != 2'd2);
  wire         id_bit_val  = buf0[id_bit];
  wire         rd_iso      = rd_port && in_iso && (reg_index == pnpcc_pkg::IDX_SERIAL_ISO);
  wire         iso_answer  = rd_iso && buf_valid && id_bit_val;
  wire         id_pop      = rd_iso && buf_valid && id_phase && (id_bit == pnpcc_pkg::ID_LAST_BIT);
  wire         res_pop     = rd_port && in_cfg && (reg_index == pnpcc_pkg::IDX_RES_DATA) && buf_valid;
  wire         buf_pop     = res_pop || id_pop;
  wire         buf_push    = fetched_vld && buf_ready && (fetch == pnpcc_pkg::FE_STREAM);
  wire         buf_flush   = wake_rewind || any_reset || (fetch != pnpcc_pkg::FE_STREAM);

  // Undo the bit reversed word layout
  // Storage keeps low byte bit 0 in the word's top bit, so a full
  // sixteen bit reversal restores the high and low bytes in place
  logic [15:0] ee_plain;
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      ee_plain[i] = ee_word[15 - i];
  end
  wire  [7:0]  ee_byte = ptr[0] ? ee_plain[15:8] : ee_plain[7:0];

  // Read answer selection
  // The range check answer takes priority: it is only enabled while the
  // device is inactive, when no configuration read can collide with it.
  // Serial isolation reads are kept out of the configuration answer so a
  // configured card never drives the isolation port
  wire         range_rd    = io_rd && io_range_hit && range_chk[pnpcc_pkg::RC_ENABLE_BIT] && !act;
  wire  [7:0]  range_val   = range_chk[pnpcc_pkg::RC_PATTERN_BIT] ? pnpcc_pkg::RC_PAT_ONE
                                                                   : pnpcc_pkg::RC_PAT_ZERO;
  wire  [7:0]  iso_val     = id_phase ? pnpcc_pkg::RC_PAT_ZERO : pnpcc_pkg::RC_PAT_ONE;
  wire         cfg_rd      = rd_port && in_cfg && (reg_index != pnpcc_pkg::IDX_SERIAL_ISO);
  logic [7:0]  next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (range_rd)
      next_rdata = range_val;
    else if (rd_iso)
      next_rdata = iso_val;
    else if (reg_index == pnpcc_pkg::IDX_RES_DATA)
      next_rdata = buf_valid ? buf0 : 8'h00;
    else if (reg_index == pnpcc_pkg::IDX_STATUS)
      next_rdata = {7'h00, buf_valid};
    else if (reg_index == pnpcc_pkg::IDX_CSN)
      next_rdata = csn;
    else if (reg_index == pnpcc_pkg::IDX_LDN)
      next_rdata = pnpcc_pkg::LDN_VALUE;
    else if (reg_index == pnpcc_pkg::IDX_ACTIVATE)
      next_rdata = {7'h00, act};
    else if (reg_index == pnpcc_pkg::IDX_RANGE_CHK)
      next_rdata = {6'h00, range_chk};
  end
  wire         rd_hit      = range_rd || iso_answer || cfg_rd;

  // Read answer registers
  // The answer byte is forced to zero outside a hit so that a wired-or
  // data path outside the block sees nothing from an idle card
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      io_rdata  <= 8'h00;
      io_rd_hit <= 1'b0;
    end
    else
    begin
      io_rdata  <= rd_hit ? next_rdata : 8'h00;
      io_rd_hit <= rd_hit;
    end
  end

  // Address port index and read port
  // Both registers are cleared by the bus reset and by the full reset
  // command, which leaves the read port at its fixed low bits only
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || any_reset)
    begin
      reg_index <= 8'h00;
      rdport    <= pnpcc_pkg::RDPORT_RESET;
    end
    else
    begin
      if (wr_addr)
        reg_index <= io_wdata;
      if (wr_rdport)
        rdport <= io_wdata;
    end
  end

  // Config control commands, held one cycle then cleared
  // Each bit stands for exactly one cycle, so a command can never be
  // applied a second time by a later unrelated strobe
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      cc_cmd <= 3'h0;
    else if (wr_cc)
      cc_cmd <= io_wdata[2:0];
    else
      cc_cmd <= 3'h0;
  end

  // Configuration state and select number
  // Wait-for-key wins over every other transition in the same cycle.
  // A select number write in isolation ends the isolation of this card.
  // The reset select number command is ignored in wait-for-key
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || any_reset)
    begin
      state <= pnpcc_pkg::ST_WAIT_KEY;
      csn   <= pnpcc_pkg::CSN_RESET;
    end
    else
    begin
      if (cc_cmd[pnpcc_pkg::CC_WFK_BIT])
        state <= pnpcc_pkg::ST_WAIT_KEY;
      else if (init_key && state == pnpcc_pkg::ST_WAIT_KEY)
        state <= pnpcc_pkg::ST_SLEEP;
      else if (wake_zero && state == pnpcc_pkg::ST_SLEEP && csn == pnpcc_pkg::CSN_RESET)
        state <= pnpcc_pkg::ST_ISOLATE;
      else if (wake_match && state == pnpcc_pkg::ST_SLEEP)
        state <= pnpcc_pkg::ST_CONFIG;
      else if (wr_wake && (in_iso || in_cfg) && io_wdata != csn)
        state <= pnpcc_pkg::ST_SLEEP;
      else if (wr_csn && in_iso)
        state <= pnpcc_pkg::ST_CONFIG;
      if (cc_cmd[pnpcc_pkg::CC_RCSN_BIT] && state != pnpcc_pkg::ST_WAIT_KEY)
        csn <= pnpcc_pkg::CSN_RESET;
      else if (wr_csn)
        csn <= io_wdata;
    end
  end

  // Fetch engine: defaults first, then the byte stream
  // After any reset the activate default word is fetched first; the
  // pointer then jumps to the serial identifier and streams from there.
  // A nonzero wake rewinds the pointer and drops a byte still in flight,
  // so the first byte after a wake is always the identifier's first byte.
  // Reload is the reset command outside wait-for-key; the full reset
  // already covers everything that reload touches
  wire         reload      = cc_cmd[pnpcc_pkg::CC_RESET_BIT] && !any_reset && state != pnpcc_pkg::ST_WAIT_KEY;
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || any_reset || reload)
    begin
      fetch       <= pnpcc_pkg::FE_LOAD;
      ptr         <= pnpcc_pkg::EE_ACT_BYTE;
      fetched     <= 8'h00;
      fetched_vld <= 1'b0;
    end
    else
    begin
      case (fetch)
        pnpcc_pkg::FE_LOAD:
        begin
          if (ee_ack)
          begin
            fetch <= pnpcc_pkg::FE_WAIT;
            ptr   <= pnpcc_pkg::EE_SERIAL_ID;
          end
        end
        pnpcc_pkg::FE_WAIT:
          fetch <= pnpcc_pkg::FE_STREAM;
        default:
        begin
          if (wake_rewind)
          begin
            ptr         <= pnpcc_pkg::EE_SERIAL_ID;
            fetched_vld <= 1'b0;
          end
          else if (!fetched_vld && ee_ack)
          begin
            fetched     <= ee_byte;
            fetched_vld <= 1'b1;
          end
          else if (buf_push)
          begin
            fetched_vld <= 1'b0;
            ptr         <= ptr + 8'h01;
          end
        end
      endcase
    end
  end

  // Activate and range check registers
  // The default load only touches the activate bit; a low strap forces
  // the device active whatever the stored default says
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || any_reset || reload)
    begin
      act       <= 1'b0;
      range_chk <= 2'b00;
    end
    else if (fetch == pnpcc_pkg::FE_LOAD && ee_ack)
      act <= !strap_s2 || ({7'h00, ee_byte[pnpcc_pkg::ACT_BIT]} == pnpcc_pkg::ACT_DEFAULT_ON);
    else
    begin
      if (wr_act)
        act <= io_wdata[pnpcc_pkg::ACT_BIT];
      if (wr_rc)
        range_chk <= io_wdata[1:0];
    end
  end

  // Two entry byte buffer between the fetch engine and the readers
  // The buffer decouples the storage fetch latency from host reads: a
  // byte is only taken when a slot is free, so a slow host loses nothing.
  // Any rewind, reset or reload empties it
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || buf_flush)
    begin
      buf0    <= 8'h00;
      buf1    <= 8'h00;
      buf_cnt <= 2'd0;
    end
    else
    begin
      if (buf_pop && buf_push)
      begin
        buf0 <= (buf_cnt == 2'd1) ? fetched : buf1;
        buf1 <= fetched;
      end
      else if (buf_pop)
      begin
        buf0    <= buf1;
        buf_cnt <= buf_cnt - 2'd1;
      end
      else if (buf_push)
      begin
        if (buf_cnt == 2'd0)
          buf0 <= fetched;
        else
          buf1 <= fetched;
        buf_cnt <= buf_cnt + 2'd1;
      end
    end
  end

  // Serial identifier bit walk, two reads per bit
  // The walk restarts whenever the card leaves isolation; the head byte
  // is popped after the second read of its last bit
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !in_iso)
    begin
      id_bit   <= 3'h0;
      id_phase <= 1'b0;
    end
    else if (rd_iso && buf_valid)
    begin
      id_phase <= !id_phase;
      if (id_phase)
        id_bit <= id_bit + 3'h1;
    end
  end

  // Outputs
  // Storage is word addressed while the pointer counts bytes
  assign read_port_addr = rdport_full;
  assign card_state     = state;
  assign card_select    = csn;
  assign device_active  = act;
  assign ee_req         = (fetch == pnpcc_pkg::FE_LOAD) || (fetch == pnpcc_pkg::FE_STREAM && !fetched_vld);
  assign ee_addr        = ptr[7:1];

endmodule : pnpcc_top

/* logic/pnpcc_pkg.sv */
// Shared constants for the plug and play card configuration control block
package pnpcc_pkg;
  // Card configuration states
  typedef enum logic [1:0] {
    ST_WAIT_KEY = 2'b00,
    ST_SLEEP    = 2'b01,
    ST_ISOLATE  = 2'b10,
    ST_CONFIG   = 2'b11
  } pnpcc_state_t;
  // Fetch engine states
  typedef enum logic [1:0] {
    FE_LOAD   = 2'b00,
    FE_WAIT   = 2'b01,
    FE_STREAM = 2'b10
  } pnpcc_fetch_t;
  // Fixed I/O ports of the configuration space
  localparam logic [15:0] ADDR_PORT      = 16'h0279;
  localparam logic [15:0] WDATA_PORT     = 16'h0a79;
  // Register indices written to the address port
  localparam logic [7:0]  IDX_SET_RDPORT = 8'h00;
  localparam logic [7:0]  IDX_SERIAL_ISO = 8'h01;
  localparam logic [7:0]  IDX_CFG_CTRL   = 8'h02;
  localparam logic [7:0]  IDX_WAKE       = 8'h03;
  localparam logic [7:0]  IDX_RES_DATA   = 8'h04;
  localparam logic [7:0]  IDX_STATUS     = 8'h05;
  localparam logic [7:0]  IDX_CSN        = 8'h06;
  localparam logic [7:0]  IDX_LDN        = 8'h07;
  localparam logic [7:0]  IDX_ACTIVATE   = 8'h30;
  localparam logic [7:0]  IDX_RANGE_CHK  = 8'h31;
  // Config control command bits
  localparam int          CC_RESET_BIT   = 0;
  localparam int          CC_WFK_BIT     = 1;
  localparam int          CC_RCSN_BIT    = 2;
  localparam logic [2:0]  CC_ALL         = 3'h7;
  // Field layouts and fixed values
  localparam int          ACT_BIT        = 0;
  localparam int          RC_PATTERN_BIT = 0;
  localparam int          RC_ENABLE_BIT  = 1;
  localparam int          STATUS_AVAIL   = 0;
  localparam logic [7:0]  RC_PAT_ONE     = 8'h55;
  localparam logic [7:0]  RC_PAT_ZERO    = 8'haa;
  localparam logic [7:0]  CSN_RESET      = 8'h00;
  localparam logic [7:0]  LDN_VALUE      = 8'h00;
  localparam logic [7:0]  ACT_DEFAULT_ON = 8'h01;
  localparam logic [1:0]  RDPORT_LOW     = 2'b11;
  localparam logic [5:0]  RDPORT_HIGH    = 6'b000000;
  localparam logic [7:0]  RDPORT_RESET   = 8'h00;
  // Storage layout
  localparam logic [7:0]  EE_ACT_BYTE    = 8'h0f;
  localparam logic [7:0]  EE_SERIAL_ID   = 8'h16;
  localparam logic [2:0]  ID_LAST_BIT    = 3'h7;
  // Host settle time after a reset
  localparam int          RESET_WAIT_US  = 1000;
  localparam int          CLK_MHZ        = 100;
  localparam int          RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
endpackage : pnpcc_pkg

/* dv/pnpcc_eeprom_model.sv */
// Behavioural serial storage answering word fetches of the card logic
`timescale 1ns/1ps
module pnpcc_eeprom_model (
  input  wire logic        ref_clk, // Clock
  input  wire logic        ee_req,  // Fetch wanted
  input  wire logic [6:0]  ee_addr, // Word address
  input  wire logic        act_def, // Default activate bit
  output logic             ee_ack,  // Word returned
  output logic      [15:0] ee_word  // Stored word
);
  int         seed = 32'h566a;
  int         wait_n = 0;
  logic [7:0] lo;
  logic [7:0] hi;
  // Byte image: byte 0x0f holds the default activate bit
  assign lo = {ee_addr, 1'b0} ^ 8'hc3;
  assign hi = ({ee_addr, 1'b1} == 8'h0f) ? {7'h00, act_def} : ({ee_addr, 1'b1} ^ 8'hc3);
  initial
  begin
    ee_ack = 0;
    ee_word = 16'h0000;
  end
  // Random answer delay; the word is junk outside the answer cycle
  always @(posedge ref_clk)
  begin
    #1;
    ee_ack = 0;
    ee_word = ~ee_word;
    if (wait_n > 1) wait_n--;
    else if (wait_n == 1)
    begin
      wait_n = 0;
      ee_ack = ee_req;
      if (ee_req) ee_word = {<<{hi, lo}};
    end
    else if (ee_req === 1'b1) wait_n = 1 + ($random(seed) & 3);
  end
endmodule : pnpcc_eeprom_model

/* dv/pnpcc_asserts.sv */
// Concurrent checks on the card configuration control ports
`timescale 1ns/1ps
module pnpcc_checker (
  input wire logic        ref_clk,        // Clock
  input wire logic        resetn,         // Reset
  input wire logic [15:0] io_addr,        // Address
  input wire logic        io_wr,          // Write
  input wire logic        io_rd,          // Read
  input wire logic [7:0]  io_wdata,       // Write data
  input wire logic        io_range_hit,   // Range decode
  input wire logic [7:0]  io_rdata,       // Answer
  input wire logic        io_rd_hit,      // Answer pulse
  input wire logic [15:0] read_port_addr, // Read port
  input wire logic [1:0]  card_state,     // State
  input wire logic [7:0]  card_select,    // Select number
  input wire logic [6:0]  ee_addr         // Word address
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] idx;
  // Index last written outside wait-for-key
  always_ff @(posedge ref_clk)
  begin
    if (!resetn) idx <= 8'h00;
    else if (io_wr && io_addr == pnpcc_pkg::ADDR_PORT && card_state != 2'b00) idx <= io_wdata;
  end
  sequence dat_s(logic [7:0] i);
    io_wr && io_addr == pnpcc_pkg::WDATA_PORT && idx == i && card_state != 2'b00;
  endsequence
  sequence rdp_s(logic [7:0] i);
    io_rd && io_addr == read_port_addr && idx == i && !io_range_hit;
  endsequence
  reset_clear_a: assert property ($rose(resetn) |-> card_state == 2'b00 && card_select == 8'h00)
    else $error("state not cleared by reset");
  ldn_zero_a: assert property (rdp_s(8'h07) ##0 card_state == 2'b11 |=> io_rd_hit && io_rdata == 8'h00)
    else $error("device number not zero");
  iso_only_a: assert property (rdp_s(8'h01) ##0 card_state != 2'b10 |=> !io_rd_hit)
    else $error("isolation read answered");
  wake_iso_a: assert property (dat_s(8'h03) ##0 (io_wdata == 0 && card_select == 0 && card_state == 2'b01)
    |=> card_state == 2'b10) else $error("zero wake did not isolate");
  wake_cfg_a: assert property (dat_s(8'h03) ##0 (io_wdata != 0 && io_wdata == card_select)
    |=> card_state == 2'b11) else $error("matching wake did not configure");
  wake_sleep_a: assert property (dat_s(8'h03) ##0 (io_wdata != card_select && card_state[1])
    |=> card_state == 2'b01) else $error("other wake did not sleep");
  rewind_a: assert property (dat_s(8'h03) ##0 io_wdata != 0 |-> ##[1:2] ee_addr == 7'h0b)
    else $error("pointer not rewound");
  rdport_a: assert property (dat_s(8'h00) ##0 card_state == 2'b10
    |=> read_port_addr == {6'h00, $past(io_wdata), 2'b11}) else $error("read port address wrong");
  wfk_cmd_a: assert property (dat_s(8'h02) ##0 io_wdata[1] |-> ##[1:2] card_state == 2'b00)
    else $error("wait-for-key not entered");
  csn_clr_a: assert property (dat_s(8'h02) ##0 io_wdata[2] |-> ##[1:2] card_select == 8'h00)
    else $error("select number not cleared");
endmodule : pnpcc_checker
bind pnpcc_top pnpcc_checker pnpcc_checker_inst (.*);

/* dv/pnpcc_bench.sv */
// Self-checking bench for the card configuration control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; $display("Error at %0t: got %h want %h", $time, a, e); end end
module pnp_isa_card_config_control_bench;
  logic        ref_clk = 0;
  logic        resetn = 0;
  logic        init_key = 0;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 0;
  logic        io_rd = 0;
  logic [7:0]  io_wdata = 8'h00;
  logic        io_range_hit = 0;
  logic        activate_strap_pin = 1;
  logic        act_def = 1;
  logic [7:0]  io_rdata;
  logic        io_rd_hit;
  logic [15:0] read_port_addr;
  logic [1:0]  card_state;
  logic [7:0]  card_select;
  logic        device_active;
  logic        ee_req;
  logic [6:0]  ee_addr;
  logic        ee_ack;
  logic [15:0] ee_word;
  logic [7:0]  expq[$];
  logic [7:0]  rp;
  logic [7:0]  x;
  int          n_errors = 0;
  int          checks_done = 0;
  int          seed = 32'h566a;
  always #5 ref_clk = ~ref_clk;
  pnpcc_top pnpcc_top_inst (.ref_clk, .resetn, .init_key, .io_addr, .io_wr, .io_rd, .io_wdata, .io_range_hit,
    .activate_strap_pin, .io_rdata, .io_rd_hit, .read_port_addr, .card_state, .card_select, .device_active,
    .ee_req, .ee_addr, .ee_ack, .ee_word);
  pnpcc_eeprom_model pnpcc_eeprom_model_inst (.ref_clk, .ee_req, .ee_addr, .act_def, .ee_ack, .ee_word);
  // One bus strobe, dropped after one cycle
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d, input logic r = 0);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_wr = w;
    io_rd = !w;
    io_wdata = d;
    io_range_hit = r;
    @(posedge ref_clk);
    #1;
    io_wr = 0;
    io_rd = 0;
    io_range_hit = 0;
  endtask : cyc
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    cyc(pnpcc_pkg::ADDR_PORT, 1, i);
    cyc(pnpcc_pkg::WDATA_PORT, 1, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic h);
    cyc(pnpcc_pkg::ADDR_PORT, 1, i);
    if (h) expq.push_back(e);
    cyc(read_port_addr, 0, 8'h00);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task automatic key;
    @(posedge ref_clk);
    #1;
    init_key = 1;
    wt(1);
    init_key = 0;
  endtask : key
  task final_report;
    `CHK(expq.size(), 0)
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Each answer is compared with the oldest note
  always @(negedge ref_clk)
  begin
    if (io_rd_hit === 1'b1 && expq.size() == 0)
    begin
      n_errors++;
      $display("Error at %0t: unexpected answer", $time);
    end
    else if (io_rd_hit === 1'b1)
    begin
      x = expq.pop_front();
      `CHK(io_rdata, x)
    end
  end
  // Watchdog for a hung run
  initial
  begin
    #100000;
    n_errors++;
    final_report;
  end
  // Main sequence
  initial
  begin
    wt(2);
    resetn = 1;
    wt(1);
    `CHK(card_state, pnpcc_pkg::ST_WAIT_KEY)
    `CHK(card_select, 8'h00)
    wt(20);
    `CHK(device_active, 1'b1)
    key;
    wr(pnpcc_pkg::IDX_WAKE, 8'h00);
    wt(2);
    `CHK(card_state, pnpcc_pkg::ST_ISOLATE)
    rp = $random(seed);
    wr(pnpcc_pkg::IDX_SET_RDPORT, rp);
    wt(2);
    `CHK(read_port_addr, {6'h00, rp, 2'b11})
    wt(10);
    rd(pnpcc_pkg::IDX_SERIAL_ISO, 8'h55, 1);
    rd(pnpcc_pkg::IDX_SERIAL_ISO, 8'haa, 1);
    wr(pnpcc_pkg::IDX_CSN, 8'h01);
    wr(pnpcc_pkg::IDX_WAKE, 8'h01);
    wt(2);
    `CHK(card_state, pnpcc_pkg::ST_CONFIG)
    $display("isolation test done");
    for (int i = 0; i < 11; i++)
    begin
      wt(12);
      rd(pnpcc_pkg::IDX_STATUS, 8'h01, 1);
      rd(pnpcc_pkg::IDX_RES_DATA, 8'h16 + i[7:0] ^ 8'hc3, 1);
    end
    rd(pnpcc_pkg::IDX_LDN, 8'h00, 1);
    wr(pnpcc_pkg::IDX_ACTIVATE, 8'h00);
    wt(2);
    `CHK(device_active, 1'b0)
    rd(pnpcc_pkg::IDX_ACTIVATE, 8'h00, 1);
    for (int k = 0; k < 2; k++)
    begin
      wr(pnpcc_pkg::IDX_RANGE_CHK, 8'h02 | k[7:0]);
      expq.push_back(k ? 8'h55 : 8'haa);
      cyc(16'h0300, 0, 8'h00, 1);
    end
    wr(pnpcc_pkg::IDX_ACTIVATE, 8'h01);
    rd(pnpcc_pkg::IDX_ACTIVATE, 8'h01, 1);
    cyc(16'h0300, 0, 8'h00, 1);
    $display("data test done");
    wr(pnpcc_pkg::IDX_ACTIVATE, 8'h00);
    wr(pnpcc_pkg::IDX_CFG_CTRL, 8'h01);
    wt(20);
    `CHK(device_active, 1'b1)
    `CHK(card_state, pnpcc_pkg::ST_CONFIG)
    `CHK(card_select, 8'h01)
    `CHK(read_port_addr, {6'h00, rp, 2'b11})
    wr(pnpcc_pkg::IDX_CFG_CTRL, 8'h02);
    wt(3);
    `CHK(card_state, pnpcc_pkg::ST_WAIT_KEY)
    `CHK(card_select, 8'h01)
    `CHK(device_active, 1'b1)
    key;
    wr(pnpcc_pkg::IDX_WAKE, 8'h01);
    wr(pnpcc_pkg::IDX_CFG_CTRL, 8'h04);
    wt(3);
    `CHK(card_select, 8'h00)
    `CHK(card_state, pnpcc_pkg::ST_CONFIG)
    wr(pnpcc_pkg::IDX_WAKE, 8'h05);
    wt(2);
    `CHK(card_state, pnpcc_pkg::ST_SLEEP)
    rd(pnpcc_pkg::IDX_SERIAL_ISO, 8'h00, 0);
    wr(pnpcc_pkg::IDX_WAKE, 8'h00);
    rp = $random(seed);
    wr(pnpcc_pkg::IDX_SET_RDPORT, rp);
    rd(pnpcc_pkg::IDX_SERIAL_ISO, 8'h55, 1);
    act_def = 0;
    activate_strap_pin = 0;
    wr(pnpcc_pkg::IDX_CFG_CTRL, 8'h07);
    wt(20);
    `CHK(card_state, pnpcc_pkg::ST_WAIT_KEY)
    `CHK(device_active, 1'b1)
    `CHK(read_port_addr, 16'h0003)
    activate_strap_pin = 1;
    resetn = 0;
    wt(2);
    resetn = 1;
    wt(20);
    `CHK(device_active, 1'b0)
    $display("command test done");
    final_report;
  end
endmodule : pnp_isa_card_config_control_bench
